/* testbench/crs_pin_peer.sv */
/*
 * Far side of pin bank B: static level on 1B, pulse train on 0B.
 * Assumes pclk timing; a driven pin shows the block's own level.
 */
module crs_pin_peer
(
	// Clock
	input wire logic       pclk,
	// Pins
	input wire logic [1:0] pin_oe,
	input wire logic [1:0] pin_out,
	output logic     [1:0] pin_in,
	// Stimulus: static levels, high clocks per 16 on 0B (0 = static)
	input wire logic [1:0] lvl,
	input wire logic [4:0] hcnt
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] cnt = 4'h0;
	wire logic [1:0] drv = {lvl[1], (hcnt == 5'h00) ? lvl[0] : ({1'b0, cnt} < hcnt)};

	always @(posedge pclk) cnt <= cnt + 4'h1;
	// Wire level resolves to whoever drives
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
endmodule // crs_pin_peer

/* testbench/crs_regs_checker.sv */
/*
 * Port checker of the register slice.
 * Assumes one pclk domain and binding onto crs_regs.
 */
module crs_regs_checker
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pins and outputs
	input wire logic [1:0]  pin_in,
	input wire logic [1:0]  pin_out,
	input wire logic [1:0]  pin_oe,
	input wire logic [1:0]  pin_level,
	input wire logic [2:0]  test_dac_b_level,
	input wire logic [6:0]  test_dac_b_units,
	input wire logic        section_three_checksum_enable,
	input wire logic        section_two_mismatch,
	input wire logic        section_three_mismatch
);
	timeunit 1ns;
	timeprecision 1ps;

	wire logic acc = psel && penable;
	wire logic rd  = acc && !pwrite;
	wire logic wr  = acc && pwrite;
	localparam logic [6:0] units_tab [8] = '{7'h01, 7'h02, 7'h04, 7'h09,
		7'h12, 7'h24, 7'h7c, 7'h77};

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ==========================================================
	// Assertions
	// Enable register lags the configuration register by one clock
	property oe_follow;
		wr && paddr == 12'h304 && pstrb[1] |-> ##2 pin_oe == $past(pwdata[9:8], 2);
	endproperty
	property cfg_follow;
		wr && paddr == 12'h300 && pstrb[1:0] == 2'b11 |-> ##1
			section_three_checksum_enable == $past(pwdata[15])
			&& test_dac_b_level == $past(pwdata[2:0]);
	endproperty
	pin_dir_a: assert property (oe_follow) else $error("pin enable wrong");
	sec3_cfg_a: assert property (cfg_follow) else $error("c0 fields wrong");
	out_gated_a: assert property ((pin_out & ~pin_oe) == 2'b00) else $error("input driven");
	dac_units_a: assert property (test_dac_b_units == units_tab[test_dac_b_level])
		else $error("dac multiple wrong");
	ready_high_a: assert property (pready) else $error("pready low");
	err_phase_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
	bad_addr_a: assert property (acc && paddr == 12'h100 |-> pslverr) else $error("no pslverr");
	upper_zero_a: assert property (rd |-> prdata[31:16] == 16'h0000) else $error("upper data set");
	a2_low_a: assert property (rd && paddr == 12'h288 |-> prdata[7:0] == 8'h00)
		else $error("a2 low byte set");
	c0_resv_a: assert property (rd && paddr == 12'h300 |-> prdata[14:3] == 12'h000)
		else $error("c0 reserved set");
	c1_top_a: assert property (rd && paddr == 12'h304 |-> prdata[15])
		else $error("c1 top clear");
	mis3_off_a: assert property (!section_three_checksum_enable
		&& !$past(section_three_checksum_enable) |-> !section_three_mismatch)
		else $error("mismatch while disabled");

	// ==========================================================
	// Coverage
	cover property (wr && paddr == 12'h304);
	cover property (pslverr);
	cover property (section_two_mismatch);
	cover property (section_three_mismatch);
endmodule // crs_regs_checker

bind crs_regs crs_regs_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pin_level,
	.test_dac_b_level, .test_dac_b_units, .section_three_checksum_enable,
	.section_two_mismatch, .section_three_mismatch);

/* testbench/crs_regs_tb.sv */
/*
 * Self-checking bench of the register slice over APB.
 * Assumes crs_defs.svh on the include path; checker bound separately.
 */
`include "crs_defs.svh"

module crs_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rdat;
	logic [3:0] pstrb = 0;
	logic pready, pslverr, rerr;
	logic [1:0] pin_in, pin_out, pin_oe, pin_level, lvl = 0;
	logic [4:0] hcnt = 0;
	logic [2:0] test_dac_b_level;
	logic [6:0] test_dac_b_units;
	logic section_three_checksum_enable, section_two_mismatch, section_three_mismatch;
	logic [6:0] tab [8] = '{7'h01, 7'h02, 7'h04, 7'h09, 7'h12, 7'h24, 7'h7c, 7'h77};
	int num_errors = 0, n_checks = 0;

	always #20 pclk = ~pclk;

	crs_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pin_level,
		.test_dac_b_level, .test_dac_b_units, .section_three_checksum_enable,
		.section_two_mismatch, .section_three_mismatch);
	crs_pin_peer peer (.pclk, .pin_oe, .pin_out, .pin_in, .lvl, .hcnt);

	// ==========================================================
	// Helpers
	task end_sim;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Waits for pready with a bound; the bench never assumes a latency
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20) chk("pready", 1, 0);
		rdat = prdata;
		rerr = pslverr;
		psel <= 0; penable <= 0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d, 4'hf);
	endtask

	task rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 0, 4'h0);
		chk(nm, e, rdat);
	endtask

	task settle;
		repeat (3) @(posedge pclk);
	endtask

	function logic [15:0] crc(input logic [15:0] c, input logic [15:0] w);
		for (int i = 15; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? `CRS_CRC_POLY : 16'h0000);
		return c;
	endfunction

	// ==========================================================
	// Scenarios
	task t_reset;
		rchk("a1", 12'h284, 0);
		rchk("a2", 12'h288, 0);
		rchk("a3", 12'h28c, 0);
		rchk("be", 12'h2f8, 0);
		rchk("c0", 12'h300, 0);
		rchk("c1", 12'h304, 32'h8000);
	endtask

	task t_fill;
		wr(12'h284, 32'hffff);
		wr(12'h288, 32'hffffffff);
		wr(12'h28c, 32'hffff);
		rchk("a1", 12'h284, 32'hffff);
		rchk("a2", 12'h288, 32'hff00);
		apb(1, 12'h28c, 32'h1234, 4'h1);
		rchk("a3", 12'h28c, 32'hff34);
		chk("oe", 0, pin_oe);
		wr(12'h2f8, 32'ha5a5);
		rchk("be", 12'h2f8, 32'ha5a5);
	endtask

	task t_sum2;
		wr(12'h3c0, 1);
		wr(12'h2f8, crc(crc(crc(`CRS_CRC_SEED, 16'hffff), 16'hff00), 16'hff34));
		settle;
		chk("mis2", 0, section_two_mismatch);
		wr(12'h284, 32'hfffe);
		settle;
		chk("mis2", 1, section_two_mismatch);
		rchk("st", 12'h3c8, 32'h0002);
		rchk("ctl", 12'h3c0, 32'h0001);
	endtask

	task t_sec3;
		logic [15:0] c;
		wr(12'h300, 32'hffff);
		rchk("c0", 12'h300, 32'h8007);
		chk("en3", 1, section_three_checksum_enable);
		for (int k = 0; k < 8; k++)
		begin
			apb(1, 12'h300, k, 4'h1);
			settle;
			chk("units", tab[k], test_dac_b_units);
		end
		c = crc(crc(`CRS_CRC_SEED, 16'h8007), 16'h8000);
		wr(12'h3c4, c);
		settle;
		chk("mis3", 0, section_three_mismatch);
		wr(12'h3c4, c ^ 16'h0001);
		settle;
		chk("mis3", 1, section_three_mismatch);
		rchk("s3", 12'h3c4, c ^ 16'h0001);
		wr(12'h300, 32'h0007);
		settle;
		chk("en3", 0, section_three_checksum_enable);
		chk("mis3", 0, section_three_mismatch);
	endtask

	task t_pins;
		logic [1:0] acc_or, acc_and;
		wr(12'h304, 32'h0301);
		settle;
		chk("oe", 3, pin_oe);
		chk("out", 1, pin_out);
		wr(12'h304, 32'h0003);
		rchk("c1", 12'h304, 32'h8003);
		chk("oe", 0, pin_oe);
		chk("out", 0, pin_out);
		// 0B decoded over 16 clocks, 1B static
		lvl <= 2'b10;
		hcnt <= 5'd12;
		wr(12'h304, 32'h0400);
		repeat (40) @(posedge pclk);
		acc_and = 2'b11;
		repeat (16) @(posedge pclk) acc_and &= pin_level;
		chk("lvl_hi", 3, acc_and);
		hcnt <= 5'd4;
		lvl <= 2'b00;
		repeat (40) @(posedge pclk);
		acc_or = 2'b00;
		repeat (16) @(posedge pclk) acc_or |= pin_level;
		chk("lvl_lo", 0, acc_or);
	endtask

	// Window length from the delay of a clean low-to-high step: N/2 < delay <= 3N/2 + 4
	task t_tbase(input int pin, input logic [1:0] code, input int len);
		int n;
		lvl <= 2'b00;
		hcnt <= 5'd0;
		wr(12'h304, pin ? 32'h0800 | ({30'h0, code} << 6) : 32'h0400 | ({30'h0, code} << 4));
		repeat (3 * len) @(posedge pclk);
		chk("tb_idle", 0, pin_level[pin]);
		lvl <= pin ? 2'b10 : 2'b01;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pin_level[pin] !== 1'b1 && n < 2 * len);
		chk("tb_min", 1, n > len / 2);
		chk("tb_max", 1, n <= len + len / 2 + 4);
	endtask

	task t_err;
		apb(1, 12'h100, 32'hffff, 4'hf);
		chk("err_w", 1, rerr);
		apb(0, 12'h100, 0, 4'h0);
		chk("err_r", 1, rerr);
		chk("data_r", 0, rdat);
		apb(0, 12'h286, 0, 4'h0);
		chk("err_mis", 1, rerr);
		rchk("a1", 12'h284, 32'hfffe);
		chk("err_ok", 0, rerr);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		t_reset;
		t_fill;
		t_sum2;
		t_sec3;
		t_pins;
		t_tbase(0, 2'b00, 16);
		t_tbase(1, 2'b01, 64);
		t_tbase(0, 2'b10, 256);
		t_tbase(1, 2'b11, 1024);
		t_err;
		end_sim;
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		end_sim;
	end
endmodule // crs_regs_tb

/* verilog/crs_defs.svh */
/*
 * Constants of the filler, checksum and pin bank B register slice.
 * Assumes inclusion by bare name from the testbench and the design file.
 */
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define CRS_IDX_FILLER_ONE    8'ha1
`define CRS_IDX_FILLER_TWO    8'ha2
`define CRS_IDX_FILLER_THREE  8'ha3
`define CRS_IDX_SEC_TWO_SUM   8'hbe
`define CRS_IDX_SEC_THREE_CFG 8'hc0
`define CRS_IDX_PIN_BANK_B    8'hc1
`define CRS_IDX_CHECK_CTRL    8'hf0
`define CRS_IDX_SEC_THREE_SUM 8'hf1
`define CRS_IDX_CHECK_STATUS  8'hf2

// ==========================================================
// Reset values
`define CRS_RST_FILLER        16'h0000
`define CRS_RST_SUM           16'h0000
`define CRS_RST_SEC_THREE_CFG 16'h0000
`define CRS_RST_PIN_BANK_B    16'h8000

// ==========================================================
// Writable masks and fixed bits
`define CRS_MASK_FILLER_TWO   16'hff00
`define CRS_MASK_SEC_THREE    16'h8007
`define CRS_MASK_PIN_BANK_B   16'h7fff
`define CRS_FIXED_PIN_BANK_B  16'h8000

// ==========================================================
// Field positions
`define CRS_BIT_SEC_THREE_EN  15
`define CRS_BIT_DIR0          8
`define CRS_BIT_FMT0          10
`define CRS_BIT_TB0_LO        4
`define CRS_BIT_OUT0          0
`define CRS_BIT_SEC_TWO_EN    0

// ==========================================================
// Pulse decode time bases, master clock periods
`define CRS_TB_CODE0          11'd16
`define CRS_TB_CODE1          11'd64
`define CRS_TB_CODE2          11'd256
`define CRS_TB_CODE3          11'd1024

// ==========================================================
// Checksum polynomial and seed
`define CRS_CRC_POLY          16'h1021
`define CRS_CRC_SEED          16'hffff

`endif

/* verilog/crs_pkg.sv */
/*
 * Types of the filler, checksum and pin bank B register slice.
 * Assumes crs_defs.svh is on the include path.
 */
package crs_pkg;

	// ==========================================================
	// Types
	typedef logic [15:0] crs_word_type;

	typedef enum logic [1:0] {
		CRS_TB_16   = 2'b00,
		CRS_TB_64   = 2'b01,
		CRS_TB_256  = 2'b10,
		CRS_TB_1024 = 2'b11
	} crs_timebase_type;

	typedef enum logic [2:0] {
		CRS_DAC_P1  = 3'b000,
		CRS_DAC_P2  = 3'b001,
		CRS_DAC_P4  = 3'b010,
		CRS_DAC_P9  = 3'b011,
		CRS_DAC_P18 = 3'b100,
		CRS_DAC_P36 = 3'b101,
		CRS_DAC_N4  = 3'b110,
		CRS_DAC_N9  = 3'b111
	} crs_dac_code_type;

endpackage

/* verilog/crs_regs.sv */
/*
 * APB register slice: filler words, section checksums, test DAC B level
 * and pin bank B with static and pulse-width input decoding.
 * Assumes pclk is the 25 MHz master clock and that the APB master keeps
 * the usual setup/access sequence; pin inputs are synchronous to pclk.
 */
// What this block does
// R01 - Filler fields store what is written and read it back, steering nothing but the section-two checksum.
// R02 - Filler words A1h, A2h and A3h feed the section-two checksum.
// R03 - At A2h only bits 15:8 are writable; bits 7:0 read as zero.
// R04 - The three filler words reset to zero.
// R05 - A 16-bit read/write register at BEh holds the section-two checksum.
// R06 - The section-two checksum register resets to zero.
// R07 - Bit 15 at C0h enables the section-three checksum, reset off.
// R08 - Bits 2:0 at C0h pick the test DAC B multiple 1,2,4,9,18,36,-4,-9.
// R09 - Bits 14:3 at C0h read zero and the whole register resets to zero.
// R10 - The pin bank B register at C1h resets to 8000h with bit 15 reading one.
// R11 - Bits 9 and 8 make pins 1B and 0B outputs when set, inputs when clear.
// R12 - Bits 1 and 0 give the driven level of output pins, ignored for inputs.
// R13 - Bits 11 and 10 choose static or pulse-width decoding for inputs only.
// R14 - Fields 7:6 and 5:4 pick a 16, 64, 256 or 1024 clock decode window.
// R15 - An enabled section checksum is recomputed and a mismatch is flagged.
`include "crs_defs.svh"

module crs_regs
(
	// APB clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Pin bank B, bit 0 is pin 0B
	input  wire logic [1:0]  pin_in,
	output logic      [1:0]  pin_out,
	output logic      [1:0]  pin_oe,
	output logic      [1:0]  pin_level,
	// Test DAC B
	output logic      [2:0]  test_dac_b_level,
	output logic      [6:0]  test_dac_b_units,
	// Checksum
	output logic             section_three_checksum_enable,
	output logic             section_two_mismatch,
	output logic             section_three_mismatch
);

	// ==========================================================
	// Checksum step, one word MSB first
	function automatic crs_pkg::crs_word_type crc_word(
		input crs_pkg::crs_word_type crc_in,
		input crs_pkg::crs_word_type word
	);
		crs_pkg::crs_word_type c;
		logic                  fb;
		c = crc_in;
		for (int i = 15; i >= 0; i--)
		begin
			fb = c[15] ^ word[i];
			c = {c[14:0], 1'b0};
			if (fb)
				c = c ^ `CRS_CRC_POLY;
		end
		return c;
	endfunction

	// ==========================================================
	// Storage
	crs_pkg::crs_word_type filler_one_reg;
	crs_pkg::crs_word_type filler_two_reg;
	crs_pkg::crs_word_type filler_three_reg;
	crs_pkg::crs_word_type sec_two_sum_reg;
	crs_pkg::crs_word_type sec_three_cfg_reg;
	crs_pkg::crs_word_type pin_bank_b_reg;
	crs_pkg::crs_word_type sec_three_sum_reg;
	logic                  sec_two_en_reg;
	logic                  sec_two_mis_reg;
	logic                  sec_three_mis_reg;
	logic [31:0]           prdata_reg;
	logic                  pslverr_reg;
	logic [1:0]            pin_out_reg;
	logic [1:0]            pin_oe_reg;
	logic [1:0]            pin_level_reg;

	// ==========================================================
	// Address decode
	wire logic [7:0]            idx        = paddr[9:2];
	wire logic                  aligned    = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
	wire logic                  setup      = psel && !penable;
	wire logic                  access     = psel && penable;
	wire logic                  wr_en      = access && pwrite && !pslverr_reg;
	wire crs_pkg::crs_word_type lane_mask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	wire crs_pkg::crs_word_type wdata      = pwdata[15:0];

	wire logic sel_f1 = aligned && (idx == `CRS_IDX_FILLER_ONE);
	wire logic sel_f2 = aligned && (idx == `CRS_IDX_FILLER_TWO);
	wire logic sel_f3 = aligned && (idx == `CRS_IDX_FILLER_THREE);
	wire logic sel_s2 = aligned && (idx == `CRS_IDX_SEC_TWO_SUM);
	wire logic sel_c0 = aligned && (idx == `CRS_IDX_SEC_THREE_CFG);
	wire logic sel_c1 = aligned && (idx == `CRS_IDX_PIN_BANK_B);
	wire logic sel_ct = aligned && (idx == `CRS_IDX_CHECK_CTRL);
	wire logic sel_s3 = aligned && (idx == `CRS_IDX_SEC_THREE_SUM);
	wire logic sel_st = aligned && (idx == `CRS_IDX_CHECK_STATUS);
	wire logic mapped = sel_f1 || sel_f2 || sel_f3 || sel_s2 || sel_c0 || sel_c1
		|| sel_ct || sel_s3 || sel_st;

	// ==========================================================
	// Read views, reserved bits forced
	wire crs_pkg::crs_word_type view_f2 = filler_two_reg & `CRS_MASK_FILLER_TWO; // R03
	wire crs_pkg::crs_word_type view_c0 = sec_three_cfg_reg & `CRS_MASK_SEC_THREE; // R09
	wire crs_pkg::crs_word_type view_c1 = pin_bank_b_reg | `CRS_FIXED_PIN_BANK_B; // R10
	wire crs_pkg::crs_word_type view_st = {10'h000, pin_level_reg, 1'b0, sec_three_mis_reg,
		sec_two_mis_reg, 1'b0};

	// Unmapped indices read as zero
	crs_pkg::crs_word_type rd_word;
	always_comb
	begin
		if (sel_f1)
			rd_word = filler_one_reg; // R01
		else if (sel_f2)
			rd_word = view_f2;
		else if (sel_f3)
			rd_word = filler_three_reg;
		else if (sel_s2)
			rd_word = sec_two_sum_reg; // R05
		else if (sel_c0)
			rd_word = view_c0;
		else if (sel_c1)
			rd_word = view_c1;
		else if (sel_ct)
			rd_word = {15'h0000, sec_two_en_reg};
		else if (sel_s3)
			rd_word = sec_three_sum_reg;
		else if (sel_st)
			rd_word = view_st;
		else
			rd_word = 16'h0000;
	end

	// ==========================================================
	// Write merge by byte lane
	function automatic crs_pkg::crs_word_type merge(
		input crs_pkg::crs_word_type old,
		input crs_pkg::crs_word_type nw,
		input crs_pkg::crs_word_type m
	);
		return (old & ~m) | (nw & m);
	endfunction

	wire crs_pkg::crs_word_type f1_next = merge(filler_one_reg, wdata, lane_mask);
	wire crs_pkg::crs_word_type f2_next = merge(filler_two_reg, wdata,
		lane_mask & `CRS_MASK_FILLER_TWO); // R03
	wire crs_pkg::crs_word_type f3_next = merge(filler_three_reg, wdata, lane_mask);
	wire crs_pkg::crs_word_type s2_next = merge(sec_two_sum_reg, wdata, lane_mask);
	wire crs_pkg::crs_word_type c0_next = merge(sec_three_cfg_reg, wdata,
		lane_mask & `CRS_MASK_SEC_THREE); // R09
	wire crs_pkg::crs_word_type c1_next = merge(pin_bank_b_reg, wdata,
		lane_mask & `CRS_MASK_PIN_BANK_B); // R10
	wire crs_pkg::crs_word_type s3_next = merge(sec_three_sum_reg, wdata, lane_mask);

	// ==========================================================
	// APB answer: decoded in setup, ready in access with no wait
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end
		else if (setup)
		begin
			prdata_reg  <= pwrite ? 32'h0000_0000 : {16'h0000, rd_word};
			pslverr_reg <= !mapped;
		end
	end

	// No wait states: answer stands in the first access cycle
	assign prdata  = prdata_reg;
	assign pready  = 1'b1;
	assign pslverr = access && pslverr_reg;

	// ==========================================================
	// Register writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			filler_one_reg    <= `CRS_RST_FILLER; // R04
			filler_two_reg    <= `CRS_RST_FILLER; // R04
			filler_three_reg  <= `CRS_RST_FILLER; // R04
			sec_two_sum_reg   <= `CRS_RST_SUM; // R06
			sec_three_cfg_reg <= `CRS_RST_SEC_THREE_CFG; // R09
			pin_bank_b_reg    <= `CRS_RST_PIN_BANK_B; // R10
			sec_three_sum_reg <= `CRS_RST_SUM;
			sec_two_en_reg    <= 1'b0;
		end
		else if (wr_en)
		begin
			if (sel_f1)
				filler_one_reg <= f1_next; // R01
			if (sel_f2)
				filler_two_reg <= f2_next; // R01
			if (sel_f3)
				filler_three_reg <= f3_next; // R01
			if (sel_s2)
				sec_two_sum_reg <= s2_next; // R05
			if (sel_c0)
				sec_three_cfg_reg <= c0_next; // R07
			if (sel_c1)
				pin_bank_b_reg <= c1_next;
			if (sel_s3)
				sec_three_sum_reg <= s3_next;
			if (sel_ct && pstrb[0])
				sec_two_en_reg <= wdata[`CRS_BIT_SEC_TWO_EN];
		end
	end

	// ==========================================================
	// Checksums over readable register images
	wire crs_pkg::crs_word_type sum_two = crc_word(crc_word(crc_word(`CRS_CRC_SEED,
		filler_one_reg), view_f2), filler_three_reg); // R02
	wire crs_pkg::crs_word_type sum_three = crc_word(crc_word(`CRS_CRC_SEED,
		view_c0), view_c1);

	// Disabled sections report no mismatch, so stale sums stay silent
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sec_two_mis_reg   <= 1'b0;
			sec_three_mis_reg <= 1'b0;
		end
		else
		begin
			sec_two_mis_reg   <= sec_two_en_reg && (sum_two != sec_two_sum_reg); // R15
			sec_three_mis_reg <= section_three_checksum_enable
				&& (sum_three != sec_three_sum_reg); // R15
		end
	end

	assign section_two_mismatch          = sec_two_mis_reg;
	assign section_three_mismatch        = sec_three_mis_reg;
	assign section_three_checksum_enable = sec_three_cfg_reg[`CRS_BIT_SEC_THREE_EN]; // R07

	// ==========================================================
	// Test DAC B level and signed multiple
	// Level shows the raw code; units give its signed multiple
	assign test_dac_b_level = sec_three_cfg_reg[2:0];

	always_comb
	begin
		case (crs_pkg::crs_dac_code_type'(sec_three_cfg_reg[2:0])) // R08
			crs_pkg::CRS_DAC_P1:  test_dac_b_units = 7'h01;
			crs_pkg::CRS_DAC_P2:  test_dac_b_units = 7'h02;
			crs_pkg::CRS_DAC_P4:  test_dac_b_units = 7'h04;
			crs_pkg::CRS_DAC_P9:  test_dac_b_units = 7'h09;
			crs_pkg::CRS_DAC_P18: test_dac_b_units = 7'h12;
			crs_pkg::CRS_DAC_P36: test_dac_b_units = 7'h24;
			crs_pkg::CRS_DAC_N4:  test_dac_b_units = 7'h7c;
			default:              test_dac_b_units = 7'h77;
		endcase
	end

	// ==========================================================
	// Pin bank B, one slice per pin
	for (genvar p = 0; p < 2; p++)
	begin : g_pin
		logic [10:0] win_cnt_reg;
		logic [10:0] high_cnt_reg;
		logic        decoded_reg;

		wire logic       dir    = pin_bank_b_reg[`CRS_BIT_DIR0 + p]; // R11
		wire logic       fmt    = pin_bank_b_reg[`CRS_BIT_FMT0 + p];
		wire logic [1:0] tb_sel = pin_bank_b_reg[`CRS_BIT_TB0_LO + 2 * p +: 2];
		logic [10:0]     tb_len;

		always_comb
		begin
			case (crs_pkg::crs_timebase_type'(tb_sel)) // R14
				crs_pkg::CRS_TB_16:  tb_len = `CRS_TB_CODE0;
				crs_pkg::CRS_TB_64:  tb_len = `CRS_TB_CODE1;
				crs_pkg::CRS_TB_256: tb_len = `CRS_TB_CODE2;
				default:             tb_len = `CRS_TB_CODE3;
			endcase
		end

		// A shorter time base picked mid-window ends that window at once if the count has already reached its new length
		wire logic        win_end   = (win_cnt_reg >= tb_len - 11'd1);
		wire logic [10:0] high_next = high_cnt_reg + {10'h000, pin_in[p]};

		// Majority of high samples over one window decides the level
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				win_cnt_reg  <= 11'd0;
				high_cnt_reg <= 11'd0;
				decoded_reg  <= 1'b0;
			end
			else if (win_end)
			begin
				win_cnt_reg  <= 11'd0;
				high_cnt_reg <= 11'd0;
				decoded_reg  <= (high_next > {1'b0, tb_len[10:1]}); // R14
			end
			else
			begin
				win_cnt_reg  <= win_cnt_reg + 11'd1;
				high_cnt_reg <= high_next;
			end
		end

		// Outputs are always static; decode applies to inputs only
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				pin_out_reg[p]   <= 1'b0;
				pin_oe_reg[p]    <= 1'b0;
				pin_level_reg[p] <= 1'b0;
			end
			else
			begin
				pin_oe_reg[p]    <= dir; // R11
				pin_out_reg[p]   <= dir && pin_bank_b_reg[`CRS_BIT_OUT0 + p]; // R12
				pin_level_reg[p] <= (!dir && fmt) ? decoded_reg : pin_in[p]; // R13
			end
		end
	end

	assign pin_out   = pin_out_reg;
	assign pin_oe    = pin_oe_reg;
	assign pin_level = pin_level_reg;

endmodule // crs_regs
